// ===== hdl/pdc_map.vh
// register map, field positions, reset values and timing counts
`ifndef PDC_MAP_VH
`define PDC_MAP_VH
`define PDC_CLK_MHZ        40
`define PDC_CLAMP_SHORT_NS 1700
`define PDC_CLAMP_LONG_NS  3400
`define PDC_CLAMP_SHORT_CYC ((`PDC_CLAMP_SHORT_NS * `PDC_CLK_MHZ) / 1000)
`define PDC_CLAMP_LONG_CYC  ((`PDC_CLAMP_LONG_NS * `PDC_CLK_MHZ) / 1000)
`define PDC_PULSE_NS       15
`define PDC_PULSE_CYC      1
`define PDC_CW             8
// register indexes (word addresses)
`define PDC_A_BANK00       4'h0
`define PDC_A_BANK01       4'h1
`define PDC_A_BANK10       4'h2
`define PDC_A_BANK11       4'h3
`define PDC_A_STATUS       4'h4
`define PDC_A_SLIM         4'h5
// bank (0,1) fields
`define PDC_B_HALF_N       9
`define PDC_B_TERM_SEL     10
// bank (1,0) fields
`define PDC_B_EQU_DIS_N    6
`define PDC_B_SLOW         19
`define PDC_B_PD_PWR_DN    2
`define PDC_B_WR_PWR_DN    3
`define PDC_B_BAND_SEL     4
`define PDC_B_QDLY_LO      0
// bank (1,1) fields
`define PDC_B_BAND_HOLD    2
`define PDC_B_OBSERVE      4
`define PDC_B_PORT_OE      9
`define PDC_B_PORT_IS      10
`define PDC_B_PREAMBLE     15
`define PDC_B_WG_POL       16
`define PDC_B_FGAIN1       18
`define PDC_B_FGAIN2       19
// reset values
`define PDC_RST_B01        20'h00200
`define PDC_RST_B10        20'h00040
`define PDC_RST_B11        20'h08008
`define PDC_RST_SLIM       8'h00
// gain codes
`define PDC_GAIN_AGC       2'h0
`define PDC_GAIN_4         2'h1
`define PDC_GAIN_8         2'h2
`define PDC_GAIN_12        2'h3
`endif

// ===== hdl/pdc_clamp.v
// post-write input clamp timer
`include "pdc_map.vh"
module pdc_clamp (
  input  wire        i_sys_clk,
  input  wire        i_nrst,
  input  wire        i_write,
  input  wire        i_slow,
  output reg         o_clamp
);
  reg [`PDC_CW-1:0] cnt_r;
  // reload one short of the tail, since the count stops at zero
  localparam [31:0] LD_LONG  = `PDC_CLAMP_LONG_CYC - 1;
  localparam [31:0] LD_SHORT = `PDC_CLAMP_SHORT_CYC - 1;
  // hold clamp during write, then count down the chosen tail
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_r   <= {`PDC_CW{1'b0}};
      o_clamp <= 1'b0;
    end else if (i_write) begin
      o_clamp <= 1'b1; // R1
      cnt_r   <= i_slow ? LD_LONG[`PDC_CW-1:0] :
                          LD_SHORT[`PDC_CW-1:0]; // R2
    end else if (cnt_r != {`PDC_CW{1'b0}}) begin
      cnt_r <= cnt_r - 8'h01;
    end else begin
      o_clamp <= 1'b0;
    end
  end
endmodule

// ===== hdl/pdc_qdelay.v
// qualification delay line, 0..3 steps of one cycle each
module pdc_qdelay (
  input  wire        i_sys_clk,
  input  wire        i_nrst,
  input  wire        i_qual,
  input  wire [1:0]  i_steps,
  output reg         o_qual_dly
);
  reg [2:0] tap_r;
  // one cycle stands in for one ~11 ns step; coarse at 40 MHz
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tap_r      <= 3'h0;
      o_qual_dly <= 1'b0;
    end else begin
      tap_r <= {tap_r[1:0], i_qual};
      case (i_steps)
        2'h0:    o_qual_dly <= i_qual;
        2'h1:    o_qual_dly <= tap_r[0];
        2'h2:    o_qual_dly <= tap_r[1];
        default: o_qual_dly <= tap_r[2]; // R9 R10
      endcase
    end
  end
endmodule

// ===== hdl/pdc_top.v
// pulse detector control: registers, clamp, gain, band switch, pins
// Notes on behaviour
// R1: clamp amp inputs during write and for a tail after it.
// R2: clamp tail is 3.4 us when slow bit high, 1.7 us otherwise.
// R3: in write mode hold agc level and block amplifier input.
// R4: configuration bit selects 68 or 130 ohm output drive.
// R5: sixteen-step pulse slimming, one setting per channel filter.
// R6: reduced-power output only when half and equalizer bits low.
// R7: fixed gain bits decode to gains 4, 8 and 12.
// R8: both fixed gain bits low leave gain under agc.
// R9: qualification signal delayed up to three steps.
// R10: delay is a two-bit field, zero to three steps.
// R11: each detected pulse issued as fixed-width pulse.
// R12: controller drives servo pins to gate and discharge detectors.
// R13: write power-down keeps amp, clamp and biases powered.
// R14: band switch deferred to hold high-then-low when enabled.
// R15: bank 1,1 bit 2 enables deferred band switch, resets low.
// R16: observe bit routes internal signals onto servo pins.
// R17: bit, reset 0, drives detected pulses out on read pin.
// R18: bit, reset 0, makes read pin an input to synchronizer.
// R19: port bits decode to hi-z, output, input, input-test.
// R20: preamble bit, reset 1, selects 3T field when high.
// R21: polarity bit, reset low, inverts write gate sense.
//
// Decided for this implementation: the register offsets and the strobed register port.
`include "pdc_map.vh"
module pdc_top (
  input  wire        i_sys_clk,
  input  wire        i_nrst,
  input  wire [3:0]  i_addr,
  input  wire [19:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [19:0] o_rdata,
  input  wire        i_write_gate,
  input  wire        i_hold,
  input  wire        i_servo_gate_sel_a,
  input  wire        i_servo_gate_sel_b,
  input  wire        i_servo_gate_sel_c,
  input  wire        i_zero_cross,
  input  wire        i_qual,
  input  wire        i_diff_pos,
  input  wire        i_diff_neg,
  input  wire        i_raw_read_pin,
  output reg         o_raw_read_pin,
  output reg         o_raw_read_pin_oe_n,
  output reg         o_sync_data,
  output reg         o_test_mode,
  output reg         o_amp_clamp,
  output reg         o_agc_hold,
  output reg         o_amp_input_block,
  output reg         o_term_130,
  output reg         o_low_power,
  output reg  [1:0]  o_gain_sel,
  output reg  [3:0]  o_slim_a,
  output reg  [3:0]  o_slim_b,
  output reg         o_band_sel,
  output reg         o_pd_power,
  output reg         o_amp_power,
  output reg         o_long_preamble_select,
  output reg  [3:0]  o_servo_gate,
  output reg         o_servo_out_a,
  output reg         o_servo_out_b,
  output reg         o_servo_out_c,
  output reg         o_servo_out_d,
  output reg         o_servo_dis,
  output reg         o_pulse
);
  reg  [19:0] bank01_r;
  reg  [19:0] bank10_r;
  reg  [19:0] bank11_r;
  reg  [7:0]  slim_r;
  reg         band_r;
  reg         band_pend_r;
  reg         hold_seen_r;
  reg         hold_d_r;
  reg         zc_d_r;
  wire        write_act;
  wire        clamp;
  wire        qual_dly;
  wire        port_oe;
  wire        port_is;
  wire        band_wr;
  wire        observe;
  wire        pulse_det;
  wire        low_pwr_req;
  reg         port_oe_n_nxt;
  reg         port_test_nxt;
  reg         port_drive_nxt;
  reg         port_to_sync_nxt;
  reg  [1:0]  gain_nxt;
  reg  [3:0]  gate_nxt;

  assign write_act = i_write_gate ^ bank11_r[`PDC_B_WG_POL]; // R21
  assign port_oe   = bank11_r[`PDC_B_PORT_OE];
  assign port_is   = bank11_r[`PDC_B_PORT_IS];
  assign observe   = bank11_r[`PDC_B_OBSERVE];
  assign band_wr   = i_wr && (i_addr == `PDC_A_BANK10);

  // qualified zero-cross rising edge, shared by every pulse consumer
  assign pulse_det   = i_zero_cross && !zc_d_r && qual_dly;
  // both power bits low; that mode can only drive the 130 ohm load
  assign low_pwr_req = !bank01_r[`PDC_B_HALF_N] &&
                       !bank10_r[`PDC_B_EQU_DIS_N];

  // read pin mode from {input select, output enable}
  always @* begin
    port_oe_n_nxt    = 1'b1;
    port_test_nxt    = 1'b0;
    port_drive_nxt   = 1'b0;
    port_to_sync_nxt = 1'b0;
    case ({port_is, port_oe})
      2'h0: begin
        port_oe_n_nxt = 1'b1; // hi-z, pulses still reach sync
      end
      2'h1: begin
        port_oe_n_nxt  = 1'b0; // R17
        port_drive_nxt = 1'b1;
      end
      2'h2: begin
        port_to_sync_nxt = 1'b1; // R18
      end
      default: begin
        port_to_sync_nxt = 1'b1;
        port_test_nxt    = 1'b1; // R19
      end
    endcase
  end

  // fixed gain pair {second, first}; both low leaves agc in charge
  always @* begin
    case ({bank11_r[`PDC_B_FGAIN2], bank11_r[`PDC_B_FGAIN1]})
      2'h2:    gain_nxt = `PDC_GAIN_4; // R7
      2'h1:    gain_nxt = `PDC_GAIN_8; // R7
      2'h3:    gain_nxt = `PDC_GAIN_12; // R7
      default: gain_nxt = `PDC_GAIN_AGC; // R8
    endcase
  end

  // one burst detector per select code 1 to 4; observe mode parks them all
  always @* begin
    gate_nxt = 4'h0;
    if (!observe) begin
      case ({i_servo_gate_sel_c, i_servo_gate_sel_b, i_servo_gate_sel_a})
        3'h1:    gate_nxt = 4'h1; // R12
        3'h2:    gate_nxt = 4'h2;
        3'h3:    gate_nxt = 4'h4;
        3'h4:    gate_nxt = 4'h8;
        default: gate_nxt = 4'h0;
      endcase
    end
  end

  pdc_clamp u_clamp (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_write   (write_act),
    .i_slow    (bank10_r[`PDC_B_SLOW]),
    .o_clamp   (clamp)
  );

  pdc_qdelay u_qdelay (
    .i_sys_clk  (i_sys_clk),
    .i_nrst     (i_nrst),
    .i_qual     (i_qual),
    .i_steps    (bank10_r[`PDC_B_QDLY_LO+1:`PDC_B_QDLY_LO]),
    .o_qual_dly (qual_dly)
  );

  // register writes; banks are write-only on the device, but read back here
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bank01_r <= `PDC_RST_B01;
      bank10_r <= `PDC_RST_B10;
      bank11_r <= `PDC_RST_B11; // R15 R17 R18 R20 R21
      slim_r   <= `PDC_RST_SLIM;
    end else if (i_wr) begin
      case (i_addr)
        `PDC_A_BANK01: bank01_r <= i_wdata;
        `PDC_A_BANK10: bank10_r <= i_wdata;
        `PDC_A_BANK11: bank11_r <= i_wdata;
        `PDC_A_SLIM:   slim_r   <= i_wdata[7:0]; // R5
        default:       slim_r   <= slim_r;
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 20'h00000;
    end else if (i_rd) begin
      case (i_addr)
        `PDC_A_BANK01: o_rdata <= bank01_r;
        `PDC_A_BANK10: o_rdata <= bank10_r;
        `PDC_A_BANK11: o_rdata <= bank11_r;
        `PDC_A_SLIM:   o_rdata <= {12'h000, slim_r};
        `PDC_A_STATUS: o_rdata <= {15'h0000, band_pend_r, band_r,
                                   o_test_mode, clamp, write_act};
        default:       o_rdata <= 20'h00000;
      endcase
    end else begin
      o_rdata <= 20'h00000;
    end
  end

  // band switch: immediate, or deferred until hold rises then falls
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      band_r      <= 1'b0;
      band_pend_r <= 1'b0;
      hold_seen_r <= 1'b0;
      hold_d_r    <= 1'b0;
    end else begin
      hold_d_r <= i_hold;
      if (!bank11_r[`PDC_B_BAND_HOLD]) begin
        band_r      <= bank10_r[`PDC_B_BAND_SEL]; // R14
        band_pend_r <= 1'b0;
        hold_seen_r <= 1'b0;
      end else if (band_wr) begin
        // a fresh write restarts the wait for a full hold cycle
        band_pend_r <= 1'b1; // R15
        hold_seen_r <= 1'b0;
      end else if (band_pend_r) begin
        if (i_hold && !hold_d_r) begin
          hold_seen_r <= 1'b1;
        end
        if (hold_seen_r && !i_hold && hold_d_r) begin
          band_r      <= bank10_r[`PDC_B_BAND_SEL]; // R14
          band_pend_r <= 1'b0;
          hold_seen_r <= 1'b0;
        end
      end
    end
  end

  // amplifier controls, gain and power
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_amp_clamp       <= 1'b0;
      o_agc_hold        <= 1'b0;
      o_amp_input_block <= 1'b0;
      o_term_130        <= 1'b0;
      o_low_power       <= 1'b0;
      o_gain_sel        <= `PDC_GAIN_AGC;
      o_slim_a          <= 4'h0;
      o_slim_b          <= 4'h0;
      o_band_sel        <= 1'b0;
      o_pd_power        <= 1'b1;
      o_amp_power       <= 1'b1;
    end else begin
      o_amp_clamp       <= clamp; // R1
      // agc frozen for write or hold, input blocked only for write itself
      o_agc_hold        <= write_act | i_hold; // R3
      o_amp_input_block <= write_act; // R3
      o_low_power       <= low_pwr_req; // R6
      // low power forces the lighter 130 ohm drive
      o_term_130        <= bank01_r[`PDC_B_TERM_SEL] || low_pwr_req; // R4 R6
      o_gain_sel        <= gain_nxt; // R7 R8
      o_slim_a   <= slim_r[3:0]; // R5
      o_slim_b   <= slim_r[7:4]; // R5
      o_band_sel <= band_r;
      o_pd_power <= !bank10_r[`PDC_B_PD_PWR_DN] &&
                    !(bank10_r[`PDC_B_WR_PWR_DN] && write_act);
      // amplifier, clamp and biases stay up in write power-down
      o_amp_power <= !bank10_r[`PDC_B_PD_PWR_DN]; // R13
    end
  end

  // pulse shaping, read pin and servo pins
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      zc_d_r                 <= 1'b0;
      o_pulse                <= 1'b0;
      o_raw_read_pin         <= 1'b0;
      o_raw_read_pin_oe_n    <= 1'b1;
      o_sync_data            <= 1'b0;
      o_test_mode            <= 1'b0;
      o_long_preamble_select <= 1'b1;
      o_servo_gate           <= 4'h0;
      o_servo_dis            <= 1'b0;
      o_servo_out_a          <= 1'b0;
      o_servo_out_b          <= 1'b0;
      o_servo_out_c          <= 1'b0;
      o_servo_out_d          <= 1'b0;
    end else begin
      zc_d_r  <= i_zero_cross;
      // one cycle (25 ns) is the nearest width to 15 ns here
      o_pulse             <= pulse_det; // R11
      o_raw_read_pin      <= port_drive_nxt && pulse_det; // R17
      o_raw_read_pin_oe_n <= port_oe_n_nxt; // R19
      o_test_mode         <= port_test_nxt; // R19
      o_sync_data         <= port_to_sync_nxt ? i_raw_read_pin :
                             pulse_det; // R18 R19
      o_long_preamble_select <= bank11_r[`PDC_B_PREAMBLE]; // R20
      // servo select pins decoded to one gate or a discharge
      o_servo_dis  <= !observe && i_servo_gate_sel_c &&
                      i_servo_gate_sel_b && i_servo_gate_sel_a; // R12
      o_servo_gate <= gate_nxt; // R12 R16
      o_servo_out_a <= observe & i_diff_pos; // R16
      o_servo_out_b <= observe & i_diff_neg; // R16
      o_servo_out_c <= observe & i_zero_cross; // R16
      o_servo_out_d <= observe & qual_dly; // R16
    end
  end
endmodule

// ===== tb/pdc_top_properties.sv
// port-level properties of the pulse detector control
module pdc_chk (
  input wire logic        i_sys_clk,
  input wire logic        i_nrst,
  input wire logic [3:0]  i_addr,
  input wire logic [19:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [19:0] o_rdata,
  input wire logic        i_write_gate,
  input wire logic        i_servo_gate_sel_a,
  input wire logic        i_servo_gate_sel_b,
  input wire logic        i_servo_gate_sel_c,
  input wire logic        i_diff_pos,
  input wire logic        o_raw_read_pin_oe_n,
  input wire logic        o_test_mode,
  input wire logic        o_amp_clamp,
  input wire logic        o_agc_hold,
  input wire logic        o_amp_input_block,
  input wire logic        o_low_power,
  input wire logic [1:0]  o_gain_sel,
  input wire logic        o_amp_power,
  input wire logic        o_long_preamble_select,
  input wire logic [3:0]  o_servo_gate,
  input wire logic        o_servo_out_a,
  input wire logic        o_pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  logic [19:0] b01_r, b10_r, b11_r;
  logic [59:0] cfg_q, cfg_qq;
  logic [7:0]  lo_cnt;
  // decoded outputs lag a write by two edges, so wait for a quiet config
  wire         wr_eff = i_write_gate ^ b11_r[16];
  wire [59:0]  cfg = {b01_r, b10_r, b11_r};
  wire         steady = (cfg == cfg_q) && (cfg_q == cfg_qq);
  logic [7:0]  tail_r; // tail length as chosen while write was active
  wire [2:0]   code = {i_servo_gate_sel_c, i_servo_gate_sel_b,
                       i_servo_gate_sel_a};
  wire [3:0]   gexp = (b11_r[4] || code == 3'h0 || code > 3'h4) ? 4'h0
                      : 4'h1 << (code - 3'h1);
  wire [19:0]  bank_v = (i_addr == 4'h1) ? b01_r
                        : (i_addr == 4'h2) ? b10_r : b11_r;
  // shadow banks and cycles since write ended (saturates, idle after reset)
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      b01_r  <= 20'h00200;
      b10_r  <= 20'h00040;
      b11_r  <= 20'h08008;
      cfg_q  <= {20'h00200, 20'h00040, 20'h08008};
      cfg_qq <= {20'h00200, 20'h00040, 20'h08008};
      lo_cnt <= 8'hFF;
      tail_r <= 8'h44;
    end else begin
      if (i_wr && i_addr == 4'h1) b01_r <= i_wdata;
      if (i_wr && i_addr == 4'h2) b10_r <= i_wdata;
      if (i_wr && i_addr == 4'h3) b11_r <= i_wdata;
      cfg_q  <= cfg;
      cfg_qq <= cfg_q;
      if (wr_eff) tail_r <= b10_r[19] ? 8'h88 : 8'h44;
      lo_cnt <= wr_eff ? 8'h00 : (lo_cnt == 8'hFF) ? lo_cnt : lo_cnt + 8'h01;
    end
  end
  a_bank_read: assert property (i_rd && i_addr >= 4'h1 && i_addr <= 4'h3
    |=> o_rdata == $past(bank_v)) else $error("bank read data wrong");
  a_port_decode: assert property (steady |->
    o_raw_read_pin_oe_n == !(b11_r[9] && !b11_r[10])
    && o_test_mode == (b11_r[9] && b11_r[10])) else $error("port mode wrong");
  a_gain_decode: assert property (steady |->
    o_gain_sel == {b11_r[18], b11_r[19]}) else $error("gain select wrong");
  a_preamble_sel: assert property (steady |->
    o_long_preamble_select == b11_r[15]) else $error("preamble wrong");
  a_low_power: assert property (steady |->
    o_low_power == !(b01_r[9] || b10_r[6])) else $error("low power wrong");
  a_amp_powered: assert property (steady && !b10_r[2] |->
    o_amp_power) else $error("amplifier lost power");
  a_write_block: assert property (wr_eff [*4] |->
    o_amp_clamp && o_amp_input_block && o_agc_hold)
    else $error("write mode outputs low");
  a_clamp_tail: assert property (lo_cnt >= 8'h03
    && lo_cnt <= tail_r - 8'h03 |-> o_amp_clamp)
    else $error("clamp dropped early");
  a_clamp_release: assert property (lo_cnt >= tail_r + 8'h04
    |-> !o_amp_clamp) else $error("clamp held too long");
  a_servo_map: assert property ($stable({code, b11_r[4]}) [*3]
    |-> o_servo_gate == gexp) else $error("servo gate wrong");
  a_observe_route: assert property ($stable({b11_r[4], i_diff_pos}) [*3]
    |-> o_servo_out_a == (b11_r[4] && i_diff_pos)) else $error("observe");
  a_pulse_single: assert property (o_pulse |=> !o_pulse)
    else $error("pulse wider than one cycle");
endmodule
bind pdc_top pdc_chk u_chk (.i_sys_clk, .i_nrst, .i_addr, .i_wdata, .i_wr,
  .i_rd, .o_rdata, .i_write_gate, .i_servo_gate_sel_a, .i_servo_gate_sel_b,
  .i_servo_gate_sel_c, .i_diff_pos, .o_raw_read_pin_oe_n, .o_test_mode,
  .o_amp_clamp, .o_agc_hold, .o_amp_input_block, .o_low_power, .o_gain_sel,
  .o_amp_power, .o_long_preamble_select, .o_servo_gate, .o_servo_out_a,
  .o_pulse);

// ===== tb/pdc_ctl_model.sv
// disk controller model driving write gate, hold and servo selects
module pdc_ctl_model (
  input  wire logic  i_clk,
  output logic       o_write_gate,
  output logic       o_hold,
  output logic [2:0] o_servo_sel
);
  timeunit 1ns;
  timeprecision 100ps;
  // pins idle low until the controller acts
  initial begin
    o_write_gate = 1'b0;
    o_hold = 1'b0;
    o_servo_sel = 3'h0;
  end
  // write gate high for n cycles; long n models a slow controller
  task automatic gate(input int n);
    @(posedge i_clk);
    o_write_gate <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_write_gate <= 1'b0;
  endtask
  // hold raised then dropped, as after a servo sector
  task automatic hold(input int n);
    @(posedge i_clk);
    o_hold <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_hold <= 1'b0;
  endtask
  // select code for gating or discharging the burst detectors
  task automatic servo(input logic [2:0] c);
    @(posedge i_clk);
    o_servo_sel <= c;
  endtask
endmodule

// ===== tb/tb_top.sv
// testbench: register access, write clamp, decodes and pin routing
`include "pdc_map.vh"
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
  fail_count++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  int fail_count = 0;
  int num_checks = 0;
  int n, tl;
  logic [3:0] np, ge, ns;
  logic i_sys_clk = 0, i_nrst = 0, i_wr = 0, i_rd = 0, pin_ext = 1;
  logic [3:0] i_addr = 4'h0;
  logic [19:0] i_wdata = 20'h0, o_rdata;
  logic i_zero_cross = 0, i_qual = 0, i_diff_pos = 0, i_diff_neg = 0;
  logic i_write_gate, i_hold, o_raw_read_pin, o_raw_read_pin_oe_n;
  logic o_sync_data, o_test_mode, o_amp_clamp, o_agc_hold, o_term_130;
  logic o_amp_input_block, o_low_power, o_band_sel, o_pd_power, o_pulse;
  logic o_amp_power, o_long_preamble_select, o_servo_dis, o_servo_out_a;
  logic o_servo_out_b, o_servo_out_c, o_servo_out_d;
  logic [1:0] o_gain_sel;
  logic [3:0] o_slim_a, o_slim_b, o_servo_gate;
  logic [2:0] sel;
  // read pin wire: the device wins while its enable is low
  wire i_raw_read_pin = o_raw_read_pin_oe_n ? pin_ext : o_raw_read_pin;
  always #12.5 i_sys_clk = ~i_sys_clk;
  pdc_top u_dut (.i_sys_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_write_gate, .i_hold, .i_servo_gate_sel_a(sel[0]),
    .i_servo_gate_sel_b(sel[1]), .i_servo_gate_sel_c(sel[2]), .i_zero_cross,
    .i_qual, .i_diff_pos, .i_diff_neg, .i_raw_read_pin, .o_raw_read_pin,
    .o_raw_read_pin_oe_n, .o_sync_data, .o_test_mode, .o_amp_clamp,
    .o_agc_hold, .o_amp_input_block, .o_term_130, .o_low_power, .o_gain_sel,
    .o_slim_a, .o_slim_b, .o_band_sel, .o_pd_power, .o_amp_power,
    .o_long_preamble_select, .o_servo_gate, .o_servo_out_a, .o_servo_out_b,
    .o_servo_out_c, .o_servo_out_d, .o_servo_dis, .o_pulse);
  pdc_ctl_model u_ctl (.i_clk(i_sys_clk), .o_write_gate(i_write_gate),
    .o_hold(i_hold), .o_servo_sel(sel));
  // one-cycle register strobes, launched just after a rising edge
  task automatic wr(input logic [3:0] a, input logic [19:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [19:0] e);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(negedge i_sys_clk);
    `CHK("rdata", e, o_rdata)
  endtask
  // settle c edges, then sample away from the edge
  task automatic wt(input int c);
    repeat (c) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200us;
    fail_count++;
    end_sim;
  end
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    rd(4'h1, 20'h00200);
    rd(4'h2, 20'h00040);
    rd(4'h3, 20'h08008);
    rd(4'hF, 20'h00000);
    `CHK("gain", 2'h0, o_gain_sel)
    `CHK("preamble", 1'b1, o_long_preamble_select)
    `CHK("term", 1'b0, o_term_130)
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(4'h3, {i[0], i[1], 7'h00, i[1], i[0], 9'h000});
      wt(3);
      `CHK("gain", i[1:0], o_gain_sel)
      `CHK("oe_n", i != 1, o_raw_read_pin_oe_n)
      `CHK("test", i == 3, o_test_mode)
      `CHK("sync", i[1], o_sync_data)
      `CHK("preamble", 1'b0, o_long_preamble_select)
    end
    $display("test port and gain done");
    for (int s = 0; s < 2; s++) begin
      wr(4'h3, 20'h08008);
      wr(4'h2, {s[0], 19'h00048});
      fork
        u_ctl.gate(8);
        begin
          wt(5);
          `CHK("block", 1'b1, o_amp_input_block)
          `CHK("agc_hold", 1'b1, o_agc_hold)
          `CHK("amp_pwr", 1'b1, o_amp_power)
          `CHK("pd_pwr", 1'b0, o_pd_power)
        end
      join
      n = 0;
      while (o_amp_clamp === 1'b1 && n < 300) begin
        @(negedge i_sys_clk);
        n++;
      end
      // tail plus two register stages, counted from the gate drop
      tl = s ? `PDC_CLAMP_LONG_CYC + 2 : `PDC_CLAMP_SHORT_CYC + 2;
      `CHK("tail", tl, n)
    end
    wr(4'h3, 20'h18008);
    wt(3);
    `CHK("pol_clamp", 1'b1, o_amp_clamp)
    wr(4'h3, 20'h08008);
    $display("test clamp done");
    wr(4'h2, 20'h00050);
    wt(2);
    `CHK("band_now", 1'b1, o_band_sel)
    wr(4'h3, 20'h0800C);
    wr(4'h2, 20'h00040);
    wt(4);
    `CHK("band_wait", 1'b1, o_band_sel)
    u_ctl.hold(3);
    wt(4);
    `CHK("band_hold", 1'b0, o_band_sel)
    $display("test band done");
    for (int c = 0; c < 8; c++) begin
      u_ctl.servo(c[2:0]);
      wt(3);
      ge = (c >= 1 && c <= 4) ? 4'h1 << (c - 1) : 4'h0;
      `CHK("gate", ge, o_servo_gate)
      `CHK("dis", c == 7, o_servo_dis)
    end
    u_ctl.servo(3'h1);
    i_diff_pos <= 1'b1;
    i_diff_neg <= 1'b1;
    i_zero_cross <= 1'b1;
    wr(4'h3, 20'h08018);
    wt(3);
    `CHK("obs_gate", 4'h0, o_servo_gate)
    `CHK("obs_a", 1'b1, o_servo_out_a)
    `CHK("obs_b", 1'b1, o_servo_out_b)
    `CHK("obs_c", 1'b1, o_servo_out_c)
    // read pin as output: pulse leaves on the pin and still feeds sync
    wr(4'h3, 20'h08208);
    @(posedge i_sys_clk);
    i_zero_cross <= 1'b0;
    i_qual <= 1'b1;
    wt(4);
    @(posedge i_sys_clk);
    i_zero_cross <= 1'b1;
    np = 4'h0;
    ge = 4'h0;
    ns = 4'h0;
    repeat (8) begin
      @(negedge i_sys_clk);
      np = np + {3'h0, o_pulse};
      ge = ge + {3'h0, o_raw_read_pin};
      ns = ns + {3'h0, o_sync_data};
    end
    `CHK("pulses", 4'h1, np)
    `CHK("pin_pulses", 4'h1, ge)
    `CHK("sync_pulses", 4'h1, ns)
    `CHK("pin_oe_n", 1'b0, o_raw_read_pin_oe_n)
    // three delay steps, watched on the fourth servo pin
    wr(4'h2, 20'h00043);
    wr(4'h3, 20'h08018);
    wt(3);
    `CHK("obs_d", 1'b1, o_servo_out_d)
    @(posedge i_sys_clk);
    i_qual <= 1'b0;
    n = 0;
    while (o_servo_out_d === 1'b1 && n < 20) begin
      @(negedge i_sys_clk);
      n++;
    end
    // three steps plus sample, delay and pin registers
    `CHK("qual_delay", 6, n)
    $display("test servo and pulse done");
    wr(4'h1, 20'h00400);
    wr(4'h2, 20'h00000);
    wr(4'h5, 20'h000A5);
    wt(3);
    `CHK("lowpow", 1'b1, o_low_power)
    `CHK("term", 1'b1, o_term_130)
    `CHK("slim", 8'hA5, {o_slim_b, o_slim_a})
    $display("test power and slim done");
    end_sim;
  end
endmodule
